//--- logic/safe_position_range_monitor.sv
// position range monitor: quadrature counters, range releases, comparison, reset and restart
// assumes an axi4-lite master on i_sys_clk and asynchronous sensor pins
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "safe_position_range_monitor_defines.svh"
module safe_position_range_monitor #(
  parameter int MS_CYCLES = 200000,
  parameter int MEAS_MS   = 4
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_resetn,
  input  wire logic [5:0]                        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [5:0]                        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [1:0]                        i_sensor_a,
  input  wire logic [1:0]                        i_sensor_b,
  input  wire logic                              i_reference,
  input  wire logic                              i_reset_req,
  input  wire logic                              i_restart_req,
  output logic [3:0]                             o_release,
  output logic                                   o_reset_required,
  output logic                                   o_restart_required,
  output logic                                   o_err_any,
  output logic                                   o_err_phase,
  output logic                                   o_err_limit,
  output logic                                   o_err_deviation,
  output safe_position_range_monitor_pkg::pos_t  o_position
);
  import safe_position_range_monitor_pkg::*;

  // quadrature step: 01 up, 10 down, 11 both lines moved
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    logic [3:0] t;
    t = {prv, cur};
    if (prv == cur) return 2'b00;
    if (prv[0] != cur[0] && prv[1] != cur[1]) return 2'b11;
    if (t == 4'b0001 || t == 4'b0111 || t == 4'b1110 || t == 4'b1000) return 2'b01;
    return 2'b10;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) r[8*k +: 8] = dat[8*k +: 8];
    end
    return r;
  endfunction

  // configuration registers
  logic [31:0] ctrl_ff;
  pos_t        min_ff, start_ff, max_ff, absdev_ff;
  pos_t        upper_ff [4];
  logic [31:0] hyst_ff;
  logic [6:0]  reldev_ff;
  logic [15:0] tol_ff;

  // pin synchronisers, two stages
  logic [6:0] meta_ff, sync_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      meta_ff <= 7'h00;
      sync_ff <= 7'h00;
    end else begin
      meta_ff <= {i_restart_req, i_reset_req, i_reference, i_sensor_b, i_sensor_a};
      sync_ff <= meta_ff;
    end
  end
  wire logic [1:0] sa = sync_ff[1:0];
  wire logic [1:0] sb = sync_ff[3:2];

  // millisecond and measuring interval enables
  logic [31:0] div_ff;
  logic [15:0] meas_ff;
  logic        ms_tick_ff, meas_tick_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      div_ff       <= 32'h0;
      meas_ff      <= 16'h0;
      ms_tick_ff   <= 1'b0;
      meas_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff   <= (div_ff == 32'(MS_CYCLES - 1));
      div_ff       <= (div_ff == 32'(MS_CYCLES - 1)) ? 32'h0 : div_ff + 32'h1;
      meas_tick_ff <= 1'b0;
      if (ms_tick_ff) begin
        meas_ff <= (meas_ff == 16'(MEAS_MS - 1)) ? 16'h0 : meas_ff + 16'h1;
        meas_tick_ff <= (meas_ff == 16'(MEAS_MS - 1));
      end
    end
  end

  // reference edge detect on synchronised level
  logic ref_prev_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) ref_prev_ff <= 1'b0;
    else           ref_prev_ff <= sync_ff[4];
  end
  wire logic ref_edge = ctrl_ff[`SPR_CTRL_REFPOL] ? (sync_ff[4] & ~ref_prev_ff) : (~sync_ff[4] & ref_prev_ff);

  // per-sensor quadrature counters with saturation at travel limits
  pos_t       pos_ff [2];
  logic [1:0] ab_prev_ff [2];
  logic [1:0] phase_err_ff, limit_err_ff;
  for (genvar s = 0; s < 2; s++) begin : g_cnt
    wire logic [1:0] stp = quad_step(ab_prev_ff[s], {sb[s], sa[s]});
    always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
        pos_ff[s]       <= `SPR_POS_RST;
        ab_prev_ff[s]   <= 2'b00;
        phase_err_ff[s] <= 1'b0;
        limit_err_ff[s] <= 1'b0;
      end else begin
        ab_prev_ff[s]   <= {sb[s], sa[s]};
        phase_err_ff[s] <= (stp == 2'b11);
        if (ref_edge) begin
          pos_ff[s]       <= start_ff;
          limit_err_ff[s] <= 1'b0;
        end else if (stp == 2'b01) begin
          if (pos_ff[s] >= max_ff) limit_err_ff[s] <= 1'b1;
          else                     pos_ff[s] <= pos_ff[s] + 32'sd1;
        end else if (stp == 2'b10) begin
          if (pos_ff[s] <= min_ff) limit_err_ff[s] <= 1'b1;
          else                     pos_ff[s] <= pos_ff[s] - 32'sd1;
        end
      end
    end
  end

  // selected output position
  logic       two_in;
  logic [2:0] sel;
  logic [1:0] cmp;
  logic signed [32:0] sum33, sel33, diff33, absdiff, absel;
  pos_t       psel;
  assign two_in = ctrl_ff[`SPR_CTRL_TWO];
  assign sel    = ctrl_ff[`SPR_CTRL_SEL_LO +: 3];
  assign cmp    = two_in ? ctrl_ff[`SPR_CTRL_CMP_LO +: 2] : CMP_OFF;
  assign sum33  = 33'(pos_ff[0]) + 33'(pos_ff[1]);
  always_comb begin
    unique case (sel)
      SEL_IN2:  psel = pos_ff[1];
      SEL_HIGH: psel = (pos_ff[0] > pos_ff[1]) ? pos_ff[0] : pos_ff[1];
      SEL_LOW:  psel = (pos_ff[0] < pos_ff[1]) ? pos_ff[0] : pos_ff[1];
      SEL_AVG:  psel = sum33[32:1];
      default:  psel = pos_ff[0];
    endcase
    if (!two_in) psel = pos_ff[0];
  end
  assign sel33   = 33'(psel);
  assign diff33  = 33'(pos_ff[0]) - 33'(pos_ff[1]);
  assign absdiff = diff33[32] ? -diff33 : diff33;
  assign absel   = sel33[32] ? -sel33 : sel33;

  // deviation check: trips only when every enabled criterion is exceeded
  logic abs_over, rel_over, dev_over;
  logic [40:0] lhs, rhs;
  assign lhs      = 41'(absdiff) * 41'(`SPR_PCT_FULL);
  assign rhs      = 41'(absel) * 41'(reldev_ff);
  assign abs_over = absdiff > 33'(absdev_ff);
  assign rel_over = lhs > rhs;
  always_comb begin
    unique case (cmp)
      CMP_ABS:     dev_over = abs_over;
      CMP_REL:     dev_over = rel_over;
      CMP_ABS_REL: dev_over = abs_over & rel_over;
      CMP_OFF:     dev_over = 1'b0;
    endcase
  end

  // tolerance timer in milliseconds
  logic [15:0] tol_cnt_ff;
  logic        dev_err_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      tol_cnt_ff <= 16'h0;
      dev_err_ff <= 1'b0;
    end else if (!dev_over) begin
      tol_cnt_ff <= 16'h0;
      dev_err_ff <= 1'b0;
    end else begin
      if (ms_tick_ff && tol_cnt_ff <= tol_ff) tol_cnt_ff <= tol_cnt_ff + 16'h1;
      dev_err_ff <= (tol_ff == 16'h0) || (tol_cnt_ff > tol_ff); // extra tick: first may come at once
    end
  end

  // configuration sanity
  logic cfg_err;
  always_comb begin
    cfg_err = (max_ff < start_ff) || (start_ff < min_ff);
    for (int i = 0; i < 4; i++) begin
      if (upper_ff[i] < min_ff || upper_ff[i] > max_ff || hyst_ff[8*i +: 7] > `SPR_HYST_MAX) cfg_err = 1'b1;
    end
    if (reldev_ff >= `SPR_PCT_FULL || tol_ff > `SPR_TOL_MAX_MS) cfg_err = 1'b1;
  end
  wire logic err_now = cfg_err | (|phase_err_ff) | (|limit_err_ff) | dev_err_ff;

  // range windows with hysteresis, settled once per measuring interval
  logic [3:0] cand, stable_ff, prev_cand_ff, held_ff;
  logic [2:0] nrng;
  assign nrng = {1'b0, ctrl_ff[`SPR_CTRL_NRNG_LO +: 2]} + 3'h1;
  for (genvar r = 0; r < 4; r++) begin : g_rng
    logic signed [33:0] lo, hi, band, wid;
    assign lo   = (r == 0) ? 34'(min_ff) : 34'(upper_ff[(r == 0) ? 0 : r - 1]);
    assign hi   = 34'(upper_ff[r]);
    assign wid  = hi - lo;
    assign band = (stable_ff[r] && !wid[33]) ? 34'((42'(wid) * 42'(hyst_ff[8*r +: 7])) / 42'(`SPR_PCT_FULL)) : 34'sd0;
    assign cand[r] = (3'(r) < nrng) && (34'(psel) > lo - band) && (34'(psel) <= hi + band);
  end
  // candidate unchanged since the last tick, this cycle included
  wire logic [3:0] held_now = held_ff & ~(cand ^ prev_cand_ff);
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      stable_ff    <= 4'h0;
      prev_cand_ff <= 4'h0;
      held_ff      <= 4'hf;
    end else begin
      held_ff <= held_now;
      prev_cand_ff <= cand;
      if (meas_tick_ff) begin
        stable_ff <= (stable_ff & ~held_now) | (cand & held_now);
        held_ff   <= 4'hf;
      end
    end
  end

  // debounce of reset and restart pulses, counted in milliseconds
  logic [8:0] need;
  logic [8:0] deb_cnt_ff [2];
  logic [1:0] deb_prev_ff, pulse_ok_ff;
  always_comb begin
    unique case (ctrl_ff[`SPR_CTRL_DEB_LO +: 2])
      2'b01:   need = `SPR_DEB_100_MS;
      2'b10:   need = `SPR_DEB_350_MS;
      default: need = 9'h000;
    endcase
  end
  for (genvar d = 0; d < 2; d++) begin : g_deb
    always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
        deb_cnt_ff[d]  <= 9'h0;
        deb_prev_ff[d] <= 1'b0;
        pulse_ok_ff[d] <= 1'b0;
      end else begin
        deb_prev_ff[d] <= sync_ff[5 + d];
        pulse_ok_ff[d] <= deb_prev_ff[d] & ~sync_ff[5 + d] & (deb_cnt_ff[d] >= need);
        if (!sync_ff[5 + d])                        deb_cnt_ff[d] <= 9'h0;
        else if (ms_tick_ff && deb_cnt_ff[d] != 9'h1ff) deb_cnt_ff[d] <= deb_cnt_ff[d] + 9'h1;
      end
    end
  end

  // error latch, reset and restart handshake, flashing
  logic       err_lat_ff, restart_wait_ff, flash_ff;
  logic [8:0] flash_cnt_ff;
  logic [3:0] stable_prev_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      err_lat_ff      <= 1'b0;
      restart_wait_ff <= 1'b0;
      stable_prev_ff  <= 4'h0;
    end else begin
      stable_prev_ff <= stable_ff;
      if (err_now)                     err_lat_ff <= 1'b1;
      else if (pulse_ok_ff[0])         err_lat_ff <= 1'b0;
      if (ctrl_ff[`SPR_CTRL_MANUAL] && |(stable_ff & ~stable_prev_ff)) restart_wait_ff <= 1'b1;
      else if (pulse_ok_ff[1] || !ctrl_ff[`SPR_CTRL_MANUAL])           restart_wait_ff <= 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      flash_cnt_ff <= 9'h0;
      flash_ff     <= 1'b0;
    end else if (ms_tick_ff) begin
      flash_cnt_ff <= (flash_cnt_ff == `SPR_FLASH_MS - 9'h1) ? 9'h0 : flash_cnt_ff + 9'h1;
      if (flash_cnt_ff == `SPR_FLASH_MS - 9'h1) flash_ff <= ~flash_ff;
    end
  end

  // registered outputs
  wire logic flash_on = ~ctrl_ff[`SPR_CTRL_FLASH] | flash_ff;
  wire logic flags_on = ctrl_ff[`SPR_CTRL_FLAGS];
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_release          <= 4'h0;
      o_reset_required   <= 1'b0;
      o_restart_required <= 1'b0;
      o_err_any          <= 1'b0;
      o_err_phase        <= 1'b0;
      o_err_limit        <= 1'b0;
      o_err_deviation    <= 1'b0;
      o_position         <= `SPR_POS_RST;
    end else begin
      o_release          <= (err_lat_ff || err_now || restart_wait_ff) ? 4'h0 : stable_ff;
      o_reset_required   <= err_lat_ff & ~err_now & flash_on;
      o_restart_required <= restart_wait_ff & ~err_lat_ff & flash_on;
      o_err_any          <= flags_on & (err_lat_ff | err_now);
      o_err_phase        <= flags_on & (|phase_err_ff);
      o_err_limit        <= flags_on & (|limit_err_ff);
      o_err_deviation    <= flags_on & dev_err_ff;
      o_position         <= psel;
    end
  end

  // axi4-lite write channel: address and data in either order
  logic        aw_ok_ff, w_ok_ff;
  logic [5:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  wire logic   do_wr = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      aw_ok_ff      <= 1'b0;
      w_ok_ff       <= 1'b0;
      awaddr_ff     <= 6'h00;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_ok_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_ok_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff <= `SPR_OFF_TOL && awaddr_ff[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ctrl_ff   <= `SPR_CTRL_RST;
      min_ff    <= `SPR_POS_RST;
      start_ff  <= `SPR_POS_RST;
      max_ff    <= `SPR_POS_RST;
      absdev_ff <= `SPR_POS_RST;
      hyst_ff   <= 32'h0;
      reldev_ff <= `SPR_RELDEV_RST;
      tol_ff    <= `SPR_TOL_RST;
      for (int i = 0; i < 4; i++) upper_ff[i] <= `SPR_POS_RST;
    end else if (do_wr) begin
      unique case (awaddr_ff)
        `SPR_OFF_CTRL:   ctrl_ff   <= merge(ctrl_ff, wdata_ff, wstrb_ff);
        `SPR_OFF_MIN:    min_ff    <= merge(min_ff, wdata_ff, wstrb_ff);
        `SPR_OFF_START:  start_ff  <= merge(start_ff, wdata_ff, wstrb_ff);
        `SPR_OFF_MAX:    max_ff    <= merge(max_ff, wdata_ff, wstrb_ff);
        6'h10, 6'h14, 6'h18, 6'h1c:
          upper_ff[awaddr_ff[3:2]] <= merge(upper_ff[awaddr_ff[3:2]], wdata_ff, wstrb_ff);
        `SPR_OFF_HYST:   hyst_ff   <= merge(hyst_ff, wdata_ff, wstrb_ff);
        `SPR_OFF_ABSDEV: absdev_ff <= merge(absdev_ff, wdata_ff, wstrb_ff);
        `SPR_OFF_RELDEV: reldev_ff <= wstrb_ff[0] ? wdata_ff[6:0] : reldev_ff;
        `SPR_OFF_TOL:    tol_ff    <= 16'(merge({16'h0, tol_ff}, wdata_ff, wstrb_ff));
        default:         ctrl_ff   <= ctrl_ff;
      endcase
    end
  end

  // axi4-lite read channel, answer one cycle after the address is taken
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      `SPR_OFF_CTRL:   rd_mux = ctrl_ff;
      `SPR_OFF_MIN:    rd_mux = min_ff;
      `SPR_OFF_START:  rd_mux = start_ff;
      `SPR_OFF_MAX:    rd_mux = max_ff;
      6'h10, 6'h14, 6'h18, 6'h1c: rd_mux = upper_ff[s_axi_araddr[3:2]];
      `SPR_OFF_HYST:   rd_mux = hyst_ff;
      `SPR_OFF_ABSDEV: rd_mux = absdev_ff;
      `SPR_OFF_RELDEV: rd_mux = {25'h0, reldev_ff};
      `SPR_OFF_TOL:    rd_mux = {16'h0, tol_ff};
      `SPR_OFF_STATUS: rd_mux = {18'h0, cfg_err, dev_err_ff, limit_err_ff, phase_err_ff,
                                 2'b00, restart_wait_ff, err_lat_ff, stable_ff};
      `SPR_OFF_POS:    rd_mux = psel;
      `SPR_OFF_POS1:   rd_mux = pos_ff[0];
      `SPR_OFF_POS2:   rd_mux = pos_ff[1];
      default:         rd_ok  = 1'b0;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/safe_position_range_monitor_defines.svh
// constant offsets, field positions, reset values and timing for the position range monitor
// assumes inclusion by bare name from the package and the design module
`ifndef SAFE_POSITION_RANGE_MONITOR_DEFINES_SVH
`define SAFE_POSITION_RANGE_MONITOR_DEFINES_SVH
// register byte offsets
`define SPR_OFF_CTRL     6'h00
`define SPR_OFF_MIN      6'h04
`define SPR_OFF_START    6'h08
`define SPR_OFF_MAX      6'h0c
`define SPR_OFF_UPPER0   6'h10
`define SPR_OFF_HYST     6'h20
`define SPR_OFF_ABSDEV   6'h24
`define SPR_OFF_RELDEV   6'h28
`define SPR_OFF_TOL      6'h2c
`define SPR_OFF_STATUS   6'h30
`define SPR_OFF_POS      6'h34
`define SPR_OFF_POS1     6'h38
`define SPR_OFF_POS2     6'h3c
// control field positions
`define SPR_CTRL_TWO     0
`define SPR_CTRL_REFPOL  1
`define SPR_CTRL_MANUAL  2
`define SPR_CTRL_DEB_LO  3
`define SPR_CTRL_FLASH   5
`define SPR_CTRL_FLAGS   6
`define SPR_CTRL_CMP_LO  7
`define SPR_CTRL_SEL_LO  9
`define SPR_CTRL_NRNG_LO 12
// reset values
`define SPR_CTRL_RST     32'h0000_040a
`define SPR_POS_RST      32'h0000_0000
`define SPR_RELDEV_RST   7'h01
`define SPR_TOL_RST      16'h0000
// timing in milliseconds, then hysteresis and relative limits in percent
`define SPR_DEB_100_MS   9'h064
`define SPR_DEB_350_MS   9'h15e
`define SPR_TOL_MAX_MS   16'hea60
`define SPR_FLASH_MS     9'h0fa
`define SPR_HYST_MAX     7'h32
`define SPR_PCT_FULL     7'h64
`endif

//--- logic/safe_position_range_monitor_pkg.sv
// types shared by the position range monitor
// assumes the defines header sits beside it
`default_nettype none
`include "safe_position_range_monitor_defines.svh"
package safe_position_range_monitor_pkg;
  typedef logic signed [31:0] pos_t;
  typedef enum logic [1:0] {
    CMP_OFF     = 2'b00,
    CMP_ABS     = 2'b01,
    CMP_REL     = 2'b10,
    CMP_ABS_REL = 2'b11
  } cmp_mode_e;
  typedef enum logic [2:0] {
    SEL_IN1  = 3'b000,
    SEL_IN2  = 3'b001,
    SEL_HIGH = 3'b010,
    SEL_LOW  = 3'b011,
    SEL_AVG  = 3'b100
  } sel_mode_e;
endpackage
`default_nettype wire

//--- bench/safe_position_range_monitor_properties.sv
// handshake and release timing checks for the position range monitor
// assumes binding onto the design's top module ports
`timescale 1ns/1ps
`default_nettype none
module spr_properties #(
  parameter int MS_CYCLES = 200000,
  parameter int MEAS_MS   = 4
) (
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  o_release,
  input wire logic        o_err_any,
  input wire logic        o_err_phase,
  input wire logic        o_err_limit,
  input wire logic        o_err_deviation
);
  localparam int INTERVAL = MS_CYCLES * MEAS_MS;
  logic [31:0] gap_ff;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // cycles since a release bit last rose
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn)
      gap_ff <= 32'hffff_ffff;
    else if (|(o_release & ~$past(o_release)))
      gap_ff <= 32'h0000_0000;
    else if (gap_ff < 32'hffff_ffff)
      gap_ff <= gap_ff + 32'h0000_0001;
  end
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
  property p_w_pulse; s_axi_wready |=> !s_axi_wready; endproperty
  a_w_pulse: assert property (p_w_pulse) else $error("wready longer than one cycle");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("rvalid late");
  property p_err_sum; o_err_phase || o_err_limit || o_err_deviation |-> o_err_any; endproperty
  a_err_sum: assert property (p_err_sum) else $error("error without collective flag");
  property p_err_kill; o_err_any |-> o_release == 4'h0; endproperty
  a_err_kill: assert property (p_err_kill) else $error("release during error");
  property p_rel_gap; |(o_release & ~$past(o_release)) |-> gap_ff >= INTERVAL - 1; endproperty
  a_rel_gap: assert property (p_rel_gap) else $error("release rose inside interval");
  c_rel: cover property ($rose(o_release[0]));
  c_dev: cover property ($rose(o_err_deviation));
  c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind safe_position_range_monitor spr_properties #(.MS_CYCLES(MS_CYCLES), .MEAS_MS(MEAS_MS)) u_spr_properties (
  .i_sys_clk, .i_resetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .o_release, .o_err_any, .o_err_phase,
  .o_err_limit, .o_err_deviation);
`default_nettype wire

//--- bench/quad_sensor_model.sv
// two quadrature sensors, one gray code step per pulse
// assumes step pulses spaced well beyond the input synchroniser
`timescale 1ns/1ps
`default_nettype none
module quad_sensor_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_step,
  input  wire logic       i_up,
  output logic [1:0]      o_a,
  output logic [1:0]      o_b
);
  logic [1:0] ph_ff [2] = '{2'b00, 2'b00};
  // step each sensor up or down
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (i_step[k])
        ph_ff[k] <= i_up ? ph_ff[k] + 2'd1 : ph_ff[k] - 2'd1;
    end
  end
  // only one line toggles per step, never a phase fault
  assign o_a = {ph_ff[1][1], ph_ff[0][1]};
  assign o_b = {ph_ff[1][1] ^ ph_ff[1][0], ph_ff[0][1] ^ ph_ff[0][0]};
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the position range monitor
// assumes design, package and sensor model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "safe_position_range_monitor_defines.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb_top;
  import safe_position_range_monitor_pkg::*;
  logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_reference = 1'b0, i_reset_req = 1'b0, i_restart_req = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        o_reset_required, o_restart_required, o_err_any, o_err_deviation;
  logic [1:0]  s_axi_bresp, i_sensor_a, i_sensor_b, step = '0;
  logic [3:0]  o_release;
  pos_t        o_position;
  int          errors = 0, tests_run = 0, d, n;
  int          ex [5];
  safe_position_range_monitor #(.MS_CYCLES(20), .MEAS_MS(2)) u_safe_position_range_monitor (
    .i_sys_clk, .i_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready, .i_sensor_a, .i_sensor_b,
    .i_reference, .i_reset_req, .i_restart_req, .o_release, .o_reset_required, .o_restart_required,
    .o_err_any, .o_err_phase(), .o_err_limit(), .o_err_deviation, .o_position);
  quad_sensor_model u_quad_sensor_model (.i_clk(i_sys_clk), .i_step(step), .i_up(1'b1), .o_a(i_sensor_a),
    .o_b(i_sensor_b));
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  // verdict and end of run
  task automatic end_sim();
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge i_sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge i_sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask
  // read one word into rv
  task automatic rd(input logic [5:0] a);
    @(posedge i_sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge i_sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rv = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  // quadrature steps on the chosen sensors
  task automatic mv(input logic [1:0] ch, input int cnt);
    repeat (cnt) begin
      step <= ch;
      @(posedge i_sys_clk);
      step <= 2'b00;
      repeat (7) @(posedge i_sys_clk);
    end
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(`SPR_OFF_CTRL);
    `CHK(rv, `SPR_CTRL_RST)
    rd(`SPR_OFF_MIN);
    `CHK(rv, 32'h0000_0000)
    rd(`SPR_OFF_RELDEV);
    `CHK(rv, 32'h0000_0001)
    wr(`SPR_OFF_POS, 32'h0000_0001, 2'b10);
    wr(`SPR_OFF_MAX, 32'h0000_0064, 2'b00);
    wr(`SPR_OFF_UPPER0, 32'h0000_0032, 2'b00);
    wr(`SPR_OFF_MIN, 32'hffff_ff9c, 2'b00);
    wr(`SPR_OFF_START, 32'h0000_000a, 2'b00);
    wr(`SPR_OFF_ABSDEV, 32'h0000_0001, 2'b00);
    wr(`SPR_OFF_CTRL, 32'h0000_044b, 2'b00);
    i_reference <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_reference <= 1'b0;
    rd(`SPR_OFF_POS2);
    `CHK(rv, 32'h0000_000a)
    mv(2'b01, 5);
    rd(`SPR_OFF_POS1);
    d = ($signed(rv) > 10) ? 1 : -1;
    `CHK(rv, 32'(10 + 5 * d))
    mv(2'b10, 3);
    ex = '{10 + 5 * d, 10 + 3 * d, 11 + 4 * d, 9 + 4 * d, 10 + 4 * d};
    for (int k = 0; k < 5; k++) begin
      wr(`SPR_OFF_CTRL, 32'h0000_004b | (k << 9), 2'b00);
      repeat (100) @(posedge i_sys_clk);
      `CHK(o_position, pos_t'(ex[k]))
    end
    `CHK(o_release, 4'h1)
    wr(`SPR_OFF_CTRL, 32'h0000_00ca, 2'b00);
    repeat (200) @(posedge i_sys_clk);
    `CHK(o_err_deviation, 1'b0)
    wr(`SPR_OFF_TOL, 32'h0000_0002, 2'b00);
    wr(`SPR_OFF_CTRL, 32'h0000_00cb, 2'b00);
    for (n = 0; n < 600 && o_err_deviation !== 1'b1; n++) @(posedge i_sys_clk);
    `CHK(n >= 40, 1'b1)
    `CHK(n < 200, 1'b1)
    `CHK(o_err_deviation, 1'b1)
    `CHK(o_err_any, 1'b1)
    `CHK(o_release, 4'h0)
    wr(`SPR_OFF_CTRL, 32'h0000_004b, 2'b00);
    repeat (20) @(posedge i_sys_clk);
    `CHK(o_reset_required, 1'b1)
    for (int k = 0; k < 2; k++) begin
      i_reset_req <= 1'b1;
      repeat (1000 + 1100 * k) @(posedge i_sys_clk);
      i_reset_req <= 1'b0;
      repeat (20) @(posedge i_sys_clk);
      `CHK(o_reset_required, 1'(1 - k))
    end
    repeat (200) @(posedge i_sys_clk);
    `CHK(o_release, 4'h1)
    wr(`SPR_OFF_CTRL, 32'h0000_004f, 2'b00);
    wr(`SPR_OFF_UPPER0, 32'h0000_0000, 2'b00);
    repeat (100) @(posedge i_sys_clk);
    `CHK(o_release, 4'h0)
    wr(`SPR_OFF_UPPER0, 32'h0000_0032, 2'b00);
    repeat (100) @(posedge i_sys_clk);
    `CHK(o_restart_required, 1'b1)
    i_restart_req <= 1'b1;
    repeat (2100) @(posedge i_sys_clk);
    i_restart_req <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    `CHK(o_release, 4'h1)
    end_sim();
  end
endmodule
`default_nettype wire
